/* pkg/nfpi_pkg.sv */
// package: nand pin controller constants and types
package nfpi_pkg;
  localparam int unsigned NFPI_CLK_HZ = 25_000_000;
  localparam int unsigned NFPI_RECOVERY_US = 10;
  localparam int unsigned NFPI_RECOVERY_CYC =
    (NFPI_RECOVERY_US * (NFPI_CLK_HZ / 1_000_000));
  localparam int unsigned NFPI_STROBE_CYC = 2;
  localparam int unsigned NFPI_SYNC_CYC = 2;
  localparam int unsigned NFPI_PAGES_PER_BLOCK = 32;
  localparam int unsigned NFPI_MAIN_BYTES_X8 = 512;
  localparam int unsigned NFPI_HALF_PAGE_BYTES = 256;
  localparam int unsigned NFPI_SPARE_BYTES_X8 = 16;
  localparam int unsigned NFPI_MAIN_WORDS_X16 = 256;
  localparam int unsigned NFPI_SPARE_WORDS_X16 = 8;
  localparam int unsigned NFPI_ADDR_CYCLES = 4;
  localparam logic [15:0] NFPI_BUS_RST = 16'h0000;
  localparam logic [1:0] NFPI_OP_CMD = 2'h0;
  localparam logic [1:0] NFPI_OP_ADDR = 2'h1;
  localparam logic [1:0] NFPI_OP_WDATA = 2'h2;
  localparam logic [1:0] NFPI_OP_RDATA = 2'h3;
  typedef logic [1:0] nfpi_op_t;
endpackage

/* hdl/nfpi_fifo.sv */
// file: parameterised valid/ready fifo
`timescale 1ns/1ps
module nfpi_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 16
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } nfpi_fifo_st_t;
  nfpi_fifo_st_t s_q, s_d;
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic push, pop;

  assign o_in_ready = (s_q.cnt != (AW+1)'(DEPTH));
  assign o_out_valid = (s_q.cnt != '0);
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;
  assign o_out_data = mem_q[s_q.rd];

  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.wr = (s_q.wr == AW'(DEPTH-1)) ? '0 : s_q.wr + 1'b1;
    end
    if (pop) begin
      s_d.rd = (s_q.rd == AW'(DEPTH-1)) ? '0 : s_q.rd + 1'b1;
    end
    if (push && !pop) begin
      s_d.cnt = s_q.cnt + 1'b1;
    end else if (pop && !push) begin
      s_d.cnt = s_q.cnt - 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_q[s_q.wr] <= i_in_data;
    end
  end
endmodule

/* hdl/nfpi_host.sv */
// file: host controller driving nand flash pins
`timescale 1ns/1ps
//
// Contract
// RL1 - low byte carries commands, addresses, data; device latches on write rise
// RL2 - high byte only for sixteen-bit data; commands and addresses low only
// RL3 - device floats its bus when deselected or outputs disabled
// RL4 - address latch high: each write rise captures an address byte
// RL5 - command latch high: each write rise captures a command byte
// RL6 - device selected only while chip select is low
// RL7 - chip select high during program or erase busy does not stop it
// RL8 - without tolerant option, hold chip select low through read busy
// RL9 - tolerant option: chip select high in read busy does not abort
// RL10 - each read strobe fall presents next word, column advances one
// RL11 - host waits 10 us recovery after power-up before any command
// RL12 - device holds ready/busy low during power recovery
// RL13 - host keeps write strobe high during power recovery
// RL14 - write protect low: device refuses program and erase
// RL15 - host drives write protect low during power transitions
// RL16 - ready/busy low while operation runs, high when done
// RL17 - ready/busy open drain; low means some device busy
// RL18 - erase block holds 32 pages
// RL19 - eight-bit page: two 256-byte halves plus 16 spare bytes
// RL20 - sixteen-bit page: 256 main words plus 8 spare words
// RL21 - command needs select low, cmd latch high, addr latch low, read high
// RL22 - 512-Mbit and 1-Gbit take four address cycles
// RL23 - read data leaves one word per read cycle, both latches low
// RL24 - never both latches together; read high while pulsing write
module nfpi_host
  import nfpi_pkg::*;
#(
  parameter int unsigned BUS_W = 16,
  parameter int unsigned FIFO_DEPTH = 16,
  parameter int unsigned RECOVERY_CYC = NFPI_RECOVERY_CYC,
  parameter bit CS_TOLERANT = 1'b0
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_req_valid,
  output logic o_req_ready,
  input wire logic [1:0] i_req_op,
  input wire logic [BUS_W-1:0] i_req_data,
  input wire logic i_req_last,
  input wire logic i_wp_release,
  output logic o_rd_valid,
  input wire logic i_rd_ready,
  output logic [BUS_W-1:0] o_rd_data,
  output logic o_busy,
  output logic o_powered_ready,
  output logic o_cs_n,
  output logic o_cmd_latch_strobe,
  output logic o_addr_latch_strobe,
  output logic o_we_n,
  output logic o_re_n,
  output logic o_wp_n,
  input wire logic [BUS_W-1:0] i_bus,
  output logic [BUS_W-1:0] o_bus,
  output logic o_bus_oe,
  input wire logic i_ready_busy_od
);
  typedef enum logic [2:0] {
    ST_RECOVER = 3'b000,
    ST_IDLE = 3'b001,
    ST_SETUP = 3'b010,
    ST_STROBE = 3'b011,
    ST_HOLD = 3'b100,
    ST_WAIT_BUSY = 3'b101
  } nfpi_state_t;

  localparam int unsigned CW = $clog2(RECOVERY_CYC + 1);
  // words per page including spare
  localparam int unsigned PAGE_W = (BUS_W == 16) ?
    (NFPI_MAIN_WORDS_X16 + NFPI_SPARE_WORDS_X16) :
    (2 * NFPI_HALF_PAGE_BYTES + NFPI_SPARE_BYTES_X8);
  localparam int unsigned COLW = $clog2(PAGE_W);
  localparam int unsigned PGW = $clog2(NFPI_PAGES_PER_BLOCK);

  typedef struct packed {
    nfpi_state_t st;
    logic [CW-1:0] cnt;
    nfpi_op_t op;
    logic last;
    logic cs_n;
    logic cle;
    logic ale;
    logic we_n;
    logic re_n;
    logic wp_n;
    logic oe;
    logic [BUS_W-1:0] dout;
    logic [BUS_W-1:0] rd_word;
    logic rd_push;
    logic [1:0] acnt;
    logic [COLW-1:0] col;
    logic [PGW-1:0] pg;
    logic rb_s1;
    logic rb_s2;
    logic [BUS_W-1:0] din_s1;
    logic [BUS_W-1:0] din_s2;
    logic wp_arm;
  } nfpi_host_st_t;

  nfpi_host_st_t s_q, s_d;
  logic rst_s1_q;
  logic rst_s2_q;
  logic rst_sync_n;
  logic fifo_in_ready;
  logic rb_ready;

  // reset release through two flops
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  assign rst_sync_n = rst_s2_q;
  // open-drain line low means at least one device busy
  assign rb_ready = s_q.rb_s2; // RL17

  function automatic logic op_is_write(input nfpi_op_t op);
    op_is_write = (op != NFPI_OP_RDATA);
  endfunction

  function automatic logic [BUS_W-1:0] lane_mask(input nfpi_op_t op);
    // commands and addresses use the low byte only
    lane_mask = (op == NFPI_OP_WDATA) ? '1 : BUS_W'(8'hff); // RL2
  endfunction

  function automatic logic strobe_done(input nfpi_op_t op,
                                       input logic [CW-1:0] cnt);
    // reads stay low until the synced bus shows the new word
    strobe_done = op_is_write(op) ? (cnt == CW'(NFPI_STROBE_CYC - 1))
      : (cnt == CW'(NFPI_STROBE_CYC + NFPI_SYNC_CYC - 1)); // RL10
  endfunction

  assign o_req_ready = (s_q.st == ST_IDLE) && rb_ready && fifo_in_ready;
  assign o_busy = (s_q.st != ST_IDLE) || !rb_ready;
  assign o_powered_ready = (s_q.st != ST_RECOVER);
  assign o_cs_n = s_q.cs_n;
  assign o_cmd_latch_strobe = s_q.cle;
  assign o_addr_latch_strobe = s_q.ale;
  assign o_we_n = s_q.we_n;
  assign o_re_n = s_q.re_n;
  assign o_wp_n = s_q.wp_n;
  assign o_bus = s_q.dout;
  assign o_bus_oe = s_q.oe;

  always_comb begin
    s_d = s_q;
    s_d.rd_push = 1'b0;
    s_d.rb_s1 = i_ready_busy_od;
    s_d.rb_s2 = s_q.rb_s1;
    s_d.din_s1 = i_bus;
    s_d.din_s2 = s_q.din_s1;
    unique case (s_q.st)
      ST_RECOVER: begin
        s_d.we_n = 1'b1; // RL13
        s_d.wp_n = 1'b0; // RL15
        s_d.cs_n = 1'b1;
        s_d.oe = 1'b0;
        if (s_q.cnt == CW'(RECOVERY_CYC - 1)) begin
          s_d.st = ST_IDLE; // RL11
          s_d.cnt = '0;
        end else begin
          s_d.cnt = s_q.cnt + 1'b1;
        end
      end
      ST_IDLE: begin
        if (s_q.wp_arm) begin
          s_d.wp_n = i_wp_release;
        end
        if (i_req_valid && o_req_ready) begin
          s_d.op = i_req_op;
          s_d.last = i_req_last;
          s_d.cs_n = 1'b0;
          // exclusive latch strobes
          s_d.cle = (i_req_op == NFPI_OP_CMD); // RL5 RL21 RL24
          s_d.ale = (i_req_op == NFPI_OP_ADDR); // RL4 RL22 RL24
          s_d.re_n = 1'b1; // RL24
          s_d.oe = op_is_write(i_req_op); // RL3
          s_d.dout = i_req_data & lane_mask(i_req_op); // RL1 RL2
          s_d.cnt = '0;
          s_d.st = ST_SETUP;
          if (i_req_op == NFPI_OP_CMD) begin
            s_d.acnt = '0;
          end
          if (i_req_op == NFPI_OP_ADDR) begin
            if (s_q.acnt == 2'h0) begin
              s_d.col = COLW'(i_req_data[7:0]); // RL19 RL20
            end
            if (s_q.acnt == 2'h1) begin
              s_d.pg = i_req_data[PGW-1:0]; // RL18
            end
            if (s_q.acnt != 2'h3) begin
              s_d.acnt = s_q.acnt + 1'b1; // RL22
            end
          end
        end
      end
      ST_SETUP: begin
        if (op_is_write(s_q.op)) begin
          s_d.we_n = 1'b0;
        end else begin
          s_d.re_n = 1'b0; // RL10 RL23
        end
        s_d.cnt = '0;
        s_d.st = ST_STROBE;
      end
      ST_STROBE: begin
        if (strobe_done(s_q.op, s_q.cnt)) begin
          if (op_is_write(s_q.op)) begin
            s_d.we_n = 1'b1; // RL1
          end else begin
            // sample the synchronised bus before releasing read
            s_d.rd_word = s_q.din_s2; // RL23
            s_d.rd_push = 1'b1;
            s_d.re_n = 1'b1;
          end
          s_d.cnt = '0;
          s_d.st = ST_HOLD;
        end else begin
          s_d.cnt = s_q.cnt + 1'b1;
        end
      end
      ST_HOLD: begin
        s_d.cle = 1'b0;
        s_d.ale = 1'b0;
        s_d.oe = 1'b0;
        if (s_q.last && s_q.op != NFPI_OP_RDATA) begin
          s_d.cnt = '0;
          s_d.st = ST_WAIT_BUSY;
        end else begin
          s_d.st = ST_IDLE;
        end
        if (s_q.last && s_q.op == NFPI_OP_RDATA) begin
          s_d.cs_n = 1'b1;
        end
        if (s_q.op == NFPI_OP_RDATA) begin
          if (s_q.col == COLW'(PAGE_W - 1)) begin
            // page end: device loads the next page
            s_d.col = '0; // RL19 RL20
            s_d.pg = (s_q.pg == PGW'(NFPI_PAGES_PER_BLOCK - 1)) ?
              '0 : s_q.pg + 1'b1; // RL18
            if (s_q.pg == PGW'(NFPI_PAGES_PER_BLOCK - 1)) begin
              s_d.cs_n = 1'b1; // RL18
            end else if (!s_q.last) begin
              s_d.cnt = '0;
              s_d.st = ST_WAIT_BUSY; // RL16
            end
          end else begin
            s_d.col = s_q.col + 1'b1;
          end
        end
      end
      ST_WAIT_BUSY: begin
        // select held through read busy unless device tolerates release
        s_d.cs_n = CS_TOLERANT ? 1'b1 : 1'b0; // RL8 RL9 RL7
        if (s_q.cnt != CW'(3)) begin
          s_d.cnt = s_q.cnt + 1'b1;
        end else if (rb_ready) begin
          s_d.st = ST_IDLE; // RL16
        end
      end
      default: begin
        s_d.st = ST_IDLE;
      end
    endcase
    s_d.wp_arm = (s_q.st != ST_RECOVER);
  end

  always_ff @(posedge i_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      s_q.st <= ST_RECOVER;
      s_q.cnt <= '0;
      s_q.op <= NFPI_OP_CMD;
      s_q.last <= 1'b0;
      s_q.cs_n <= 1'b1;
      s_q.cle <= 1'b0;
      s_q.ale <= 1'b0;
      s_q.we_n <= 1'b1;
      s_q.re_n <= 1'b1;
      s_q.wp_n <= 1'b0;
      s_q.oe <= 1'b0;
      s_q.dout <= BUS_W'(NFPI_BUS_RST);
      s_q.rd_word <= '0;
      s_q.rd_push <= 1'b0;
      s_q.acnt <= '0;
      s_q.col <= '0;
      s_q.pg <= '0;
      s_q.rb_s1 <= 1'b0;
      s_q.rb_s2 <= 1'b0;
      s_q.din_s1 <= '0;
      s_q.din_s2 <= '0;
      s_q.wp_arm <= 1'b0;
    end else begin
      s_q.st <= s_d.st;
      s_q.cnt <= s_d.cnt;
      s_q.op <= s_d.op;
      s_q.last <= s_d.last;
      s_q.cs_n <= s_d.cs_n;
      s_q.cle <= s_d.cle;
      s_q.ale <= s_d.ale;
      s_q.we_n <= s_d.we_n;
      s_q.re_n <= s_d.re_n;
      s_q.wp_n <= s_d.wp_n;
      s_q.oe <= s_d.oe;
      s_q.dout <= s_d.dout;
      s_q.rd_word <= s_d.rd_word;
      s_q.rd_push <= s_d.rd_push;
      s_q.acnt <= s_d.acnt;
      s_q.col <= s_d.col;
      s_q.pg <= s_d.pg;
      s_q.rb_s1 <= s_d.rb_s1;
      s_q.rb_s2 <= s_d.rb_s2;
      s_q.din_s1 <= s_d.din_s1;
      s_q.din_s2 <= s_d.din_s2;
      s_q.wp_arm <= s_d.wp_arm;
    end
  end

  // read words queue toward the user
  nfpi_fifo #(
    .WIDTH(BUS_W),
    .DEPTH(FIFO_DEPTH)
  ) u_rd_fifo (
    .i_clk(i_clk),
    .i_rst_n(rst_sync_n),
    .i_in_valid(s_q.rd_push),
    .o_in_ready(fifo_in_ready),
    .i_in_data(s_q.rd_word),
    .o_out_valid(o_rd_valid),
    .i_out_ready(i_rd_ready),
    .o_out_data(o_rd_data)
  );
endmodule

/* test/nfpi_host_chk.sv */
// checker: pin-level properties of the nand host
`timescale 1ns/1ps
module nfpi_host_chk #(
  parameter int unsigned BUS_W = 16
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_req_valid,
  input wire logic o_req_ready,
  input wire logic o_powered_ready,
  input wire logic o_cs_n,
  input wire logic o_cmd_latch_strobe,
  input wire logic o_addr_latch_strobe,
  input wire logic o_we_n,
  input wire logic o_re_n,
  input wire logic o_wp_n,
  input wire logic [BUS_W-1:0] o_bus,
  input wire logic o_bus_oe,
  input wire logic i_ready_busy_od
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_take;
    i_req_valid && o_req_ready;
  endsequence
  sequence s_wr_pulse;
    (!o_we_n && !o_cs_n && o_bus_oe)[*2] ##1 o_we_n;
  endsequence
  sequence s_rd_pulse;
    (!o_re_n && !o_cs_n && !o_bus_oe)[*4] ##1 o_re_n;
  endsequence
  sequence s_line_busy;
    !i_ready_busy_od [*3];
  endsequence
  property p_latch_excl;
    !(o_cmd_latch_strobe && o_addr_latch_strobe);
  endproperty
  a_latch_excl: assert property (p_latch_excl)
    else $error("both latch strobes high");
  property p_we_re;
    !o_we_n |-> o_re_n;
  endproperty
  a_we_re: assert property (p_we_re)
    else $error("read strobe low during write");
  property p_cmd_sel;
    o_cmd_latch_strobe && !o_we_n |-> !o_cs_n && !o_addr_latch_strobe;
  endproperty
  a_cmd_sel: assert property (p_cmd_sel)
    else $error("command cycle not selected");
  property p_low_only;
    (o_cmd_latch_strobe || o_addr_latch_strobe) && o_bus_oe
      |-> o_bus[BUS_W-1:8] == '0;
  endproperty
  a_low_only: assert property (p_low_only)
    else $error("upper byte used for command");
  property p_rec;
    !o_powered_ready |-> o_we_n && !o_wp_n && !o_req_ready;
  endproperty
  a_rec: assert property (p_rec)
    else $error("activity during recovery");
  property p_take;
    s_take |-> ##[1:3] (!o_we_n || !o_re_n);
  endproperty
  a_take: assert property (p_take)
    else $error("no strobe after accept");
  property p_wr;
    $fell(o_we_n) |-> s_wr_pulse;
  endproperty
  a_wr: assert property (p_wr)
    else $error("bad write strobe");
  property p_rd;
    $fell(o_re_n) |-> s_rd_pulse;
  endproperty
  a_rd: assert property (p_rd)
    else $error("bad read strobe");
  property p_rd_latch;
    !o_re_n |-> !o_cmd_latch_strobe && !o_addr_latch_strobe;
  endproperty
  a_rd_latch: assert property (p_rd_latch)
    else $error("latch high during read");
  property p_busy;
    s_line_busy |-> !o_req_ready;
  endproperty
  a_busy: assert property (p_busy)
    else $error("request taken while line busy");
endmodule

/* test/nfpi_dev_model.sv */
// model: flash device behind the pins
`timescale 1ns/1ps
module nfpi_dev_model #(
  parameter int unsigned REC = 8,
  parameter int unsigned BSY = 4
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_cs_n,
  input wire logic i_cle,
  input wire logic i_ale,
  input wire logic i_we_n,
  input wire logic i_re_n,
  input wire logic i_wp_n,
  input wire logic [15:0] i_host_bus,
  input wire logic i_host_oe,
  output logic [15:0] o_bus,
  output logic o_ready_busy_od
);
  logic [15:0] mem [64];
  logic [15:0] dq, last;
  logic [5:0] col;
  logic we_d, re_d;
  int rec, bsy, hold, acnt;
  initial for (int i = 0; i < 64; i++) mem[i] = 16'h1000 + 16'(i);
  assign o_ready_busy_od = (rec > 0 || bsy > 0) ? 1'b0 : 1'b1;
  assign o_bus = i_host_oe ? i_host_bus : (!i_cs_n && hold > 0) ? dq : ~last;
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rec <= REC;
      bsy <= 0;
      hold <= 0;
      acnt <= 0;
      we_d <= 1'b1;
      re_d <= 1'b1;
      last <= 16'h0000;
    end else begin
      we_d <= i_we_n;
      re_d <= i_re_n;
      if (i_host_oe || (!i_cs_n && hold > 0)) last <= o_bus;
      if (rec > 0) rec <= rec - 1;
      if (bsy > 0) bsy <= bsy - 1;
      if (hold > 0) hold <= hold - 1;
      if (!i_cs_n && !we_d && i_we_n && rec == 0) begin
        if (i_cle) begin
          bsy <= BSY;
          acnt <= 0;
        end else if (i_ale) begin
          if (acnt == 0) col <= i_host_bus[5:0];
          acnt <= acnt + 1;
        end else if (i_wp_n) begin
          mem[col] <= i_host_bus;
          col <= col + 6'h1;
        end
      end
      if (!i_cs_n && re_d && !i_re_n && i_we_n) begin
        dq <= mem[col];
        col <= col + 6'h1;
        hold <= 3;
      end
    end
  end
endmodule

/* test/test_nfpi_host.sv */
// testbench: nand host controller against the device model
`timescale 1ns/1ps
module test_nfpi_host;
  import nfpi_pkg::*;
  logic i_clk = 0, i_rst_n = 0, i_req_valid = 0, i_req_last = 0;
  logic i_wp_release = 0, i_rd_ready = 0, i_ready_busy_od;
  logic [1:0] i_req_op = 2'h0;
  logic [15:0] i_req_data = 16'h0000, i_bus, o_bus, o_rd_data;
  logic o_req_ready, o_rd_valid, o_busy, o_powered_ready, o_cs_n;
  logic o_cmd_latch_strobe, o_addr_latch_strobe, o_we_n, o_re_n;
  logic o_wp_n, o_bus_oe;
  int miscompares = 0, check_count = 0;
  always #20 i_clk = ~i_clk;
  nfpi_host #(.RECOVERY_CYC(8)) dut (.*);
  nfpi_dev_model dev (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_cs_n(o_cs_n),
    .i_cle(o_cmd_latch_strobe), .i_ale(o_addr_latch_strobe),
    .i_we_n(o_we_n), .i_re_n(o_re_n), .i_wp_n(o_wp_n), .i_host_bus(o_bus),
    .i_host_oe(o_bus_oe), .o_bus(i_bus), .o_ready_busy_od(i_ready_busy_od));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic send(input logic [1:0] op, input logic [15:0] d,
                      input logic l, output bit ok);
    int n;
    n = 0;
    ok = 0;
    @(posedge i_clk);
    i_req_op <= op;
    i_req_data <= d;
    i_req_last <= l;
    i_req_valid <= 1'b1;
    while (!ok && n < 60) begin
      @(negedge i_clk);
      ok = (o_req_ready === 1'b1);
      n++;
    end
    @(posedge i_clk);
    i_req_valid <= 1'b0;
  endtask
  task automatic get(input logic [15:0] exp);
    int n;
    n = 0;
    @(posedge i_clk);
    i_rd_ready <= 1'b1;
    do begin
      @(negedge i_clk);
      n++;
    end while (o_rd_valid !== 1'b1 && n < 60);
    chk(o_rd_data, exp);
    @(posedge i_clk);
    i_rd_ready <= 1'b0;
  endtask
  task automatic setup(input logic [7:0] c, input logic [5:0] col);
    bit ok;
    send(NFPI_OP_CMD, {8'hA5, c}, 1'b0, ok);
    send(NFPI_OP_ADDR, {10'h3FC, col}, 1'b0, ok);
    repeat (3) send(NFPI_OP_ADDR, 16'h0000, 1'b0, ok);
  endtask
  task automatic t_recover;
    int n;
    n = 0;
    chk({15'h0, o_wp_n}, 16'h0000);
    chk({15'h0, o_we_n}, 16'h0001);
    chk({15'h0, i_ready_busy_od}, 16'h0000);
    chk({15'h0, o_busy}, 16'h0001);
    while (o_powered_ready !== 1'b1 && n < 100) begin
      @(negedge i_clk);
      n++;
    end
    chk({15'h0, n >= 8}, 16'h0001);
    $display("test recover done");
  endtask
  task automatic t_rw(input logic wp, input logic [15:0] a,
                      input logic [15:0] b, input logic [15:0] c);
    bit ok;
    @(posedge i_clk);
    i_wp_release <= wp;
    setup(8'h80, 6'd3);
    send(NFPI_OP_WDATA, a, 1'b0, ok);
    send(NFPI_OP_WDATA, b, 1'b0, ok);
    send(NFPI_OP_WDATA, c, 1'b1, ok);
    setup(8'h00, 6'd3);
    send(NFPI_OP_RDATA, 16'h0000, 1'b0, ok);
    send(NFPI_OP_RDATA, 16'h0000, 1'b0, ok);
    send(NFPI_OP_RDATA, 16'h0000, 1'b1, ok);
    get(16'hA5C3);
    get(16'h5A3C);
    get(16'hFFFF);
    chk({15'h0, o_cs_n}, 16'h0001);
    $display("test write read wp=%0d done", wp);
  endtask
  task automatic t_fill;
    bit ok;
    int cnt;
    cnt = 0;
    setup(8'h00, 6'd8);
    repeat (17) begin
      send(NFPI_OP_RDATA, 16'h0000, 1'b0, ok);
      cnt += ok;
    end
    chk(16'(cnt), 16'd16);
    for (int i = 0; i < 16; i++) get(16'h1008 + 16'(i));
    send(NFPI_OP_RDATA, 16'h0000, 1'b1, ok);
    get(16'h1018);
    $display("test fifo fill done");
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(negedge i_clk);
    t_recover;
    t_rw(1'b1, 16'hA5C3, 16'h5A3C, 16'hFFFF);
    t_rw(1'b0, 16'h0000, 16'h1111, 16'h2222);
    t_fill;
    final_report;
  end
  initial begin
    #400000;
    miscompares++;
    final_report;
  end
endmodule
bind nfpi_host nfpi_host_chk #(.BUS_W(BUS_W)) u_chk (.*);
